/* File: hw/usart_rx_params.svh */
// constants for the synchronous/asynchronous serial receiver
`ifndef USART_RX_PARAMS_SVH
`define USART_RX_PARAMS_SVH

`define RX_FIFO_DEPTH  2
`define RX_CNT_FULL    2'h2
`define RX_BITS_NARROW 4'h8
`define RX_BITS_WIDE   4'h9
`define RX_WAKE_EDGES  2'h2
`define RX_DIV_RESET   16'h0000
`define RX_CHAR_RESET  9'h000
`define RX_ENT_RESET   10'h000

`endif

/* File: hw/usart_rx_pkg.sv */
// types shared by the serial receiver modules
package usart_rx_pkg;

  typedef logic [8:0] rx_char_t;
  typedef logic [9:0] rx_entry_t;

  typedef enum logic [2:0]
  {
    ST_IDLE      = 3'b000,
    ST_CLK_LO    = 3'b001,
    ST_CLK_HI    = 3'b010,
    ST_ASY_START = 3'b011,
    ST_ASY_BITS  = 3'b100
  } rx_state_t;

endpackage : usart_rx_pkg

/* File: hw/link_shifter.sv */
// slave-mode shifter clocked by the received serial clock
`timescale 1ns/1ps
`include "usart_rx_params.svh"

module link_shifter (
  input  wire logic              link_clk_i,
  input  wire logic              link_nrst_i,
  input  wire logic              wide_i,
  input  wire logic              rxd_i,
  output usart_rx_pkg::rx_char_t word_o,
  output logic                   done_tgl_o
);
  import usart_rx_pkg::*;

  rx_char_t   sh_r;
  rx_char_t   sh_nxt;
  logic [3:0] bit_r;
  logic [3:0] last;

  assign sh_nxt = {rxd_i, sh_r[8:1]};
  assign last   = wide_i ? `RX_BITS_WIDE - 4'h1 : `RX_BITS_NARROW - 4'h1;

  // =========================================================
  // trailing-edge sampling
  // held in reset while slave reception is off, so wide_i is
  // static whenever this clock can tick
  always_ff @(negedge link_clk_i or negedge link_nrst_i)
  begin
    if (!link_nrst_i)
    begin
      sh_r       <= `RX_CHAR_RESET;
      bit_r      <= 4'h0;
      word_o     <= `RX_CHAR_RESET;
      done_tgl_o <= 1'b0;
    end
    else
    begin
      sh_r <= sh_nxt;
      if (bit_r == last)
      begin
        bit_r      <= 4'h0;
        word_o     <= wide_i ? sh_nxt : {1'b0, sh_nxt[8:1]};
        done_tgl_o <= ~done_tgl_o;
      end
      else
      begin
        bit_r <= bit_r + 4'h1;
      end
    end
  end

endmodule : link_shifter

/* File: hw/usart_sync_receiver.sv */
// receive side of the serial unit: sync master/slave, async, fifo
`timescale 1ns/1ps
`include "usart_rx_params.svh"

module usart_sync_receiver (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        link_clk_i,
  input  wire logic        serial_port_enable_i,
  input  wire logic        sync_mode_i,
  input  wire logic        clock_source_select_i,
  input  wire logic        single_receive_set_i,
  input  wire logic        continuous_receive_enable_i,
  input  wire logic        nine_bit_receive_enable_i,
  input  wire logic        receive_int_enable_i,
  input  wire logic        wake_enable_i,
  input  wire logic [15:0] baud_divisor_i,
  input  wire logic        data_read_i,
  input  wire logic        rx_data_pin_i,
  output logic             rx_data_pin_o,
  output logic             rx_data_pin_oe_n_o,
  output logic             tx_clock_pin_o,
  output logic             tx_clock_pin_oe_n_o,
  output logic [7:0]       receive_data_o,
  output logic             ninth_received_bit_o,
  output logic             framing_error_flag_o,
  output logic             overrun_error_flag_o,
  output logic             single_receive_enable_o,
  output logic             receive_flag_o,
  output logic             receive_int_o,
  output logic             break_detect_o
);
  import usart_rx_pkg::*;

  logic        serial_port_enable;
  logic        continuous_receive_enable;
  logic        wide;
  logic        rxd_s1_r;
  logic        rxd_s2_r;
  logic        rxd_d_r;
  logic        rxd_edge;
  rx_state_t   st_r;
  logic [15:0] div_r;
  logic        tick;
  logic [3:0]  bit_r;
  logic [3:0]  nbits;
  rx_char_t    sh_r;
  rx_char_t    sh_nxt;
  logic        m_done_r;
  rx_char_t    m_word_r;
  logic        m_framing_error_flag_r;
  logic        stop;
  logic        wake_arm;
  logic [1:0]  wcnt_r;
  logic        wake_used_r;
  logic        wake_r;
  logic        wake_nxt;
  logic        slv_act_r;
  logic        wide_cfg_r;
  logic        link_nrst;
  rx_char_t    s_word;
  logic        s_tgl;
  logic        s_tgl_s1_r;
  logic        s_tgl_s2_r;
  logic        s_tgl_d_r;
  logic        s_done;
  logic        push;
  logic        pop;
  logic        accept;
  logic        ovr;
  rx_entry_t   pent;
  rx_entry_t   ent_r   [`RX_FIFO_DEPTH];
  rx_entry_t   ent_nxt [`RX_FIFO_DEPTH];
  logic [1:0]  cnt_r;
  logic [1:0]  cnt_nxt;
  logic        overrun_error_flag_cont_r;
  logic        rflag_nxt;

  assign serial_port_enable     = serial_port_enable_i;
  assign continuous_receive_enable     = continuous_receive_enable_i;
  assign wide     = nine_bit_receive_enable_i;
  assign nbits    = wide ? `RX_BITS_WIDE : `RX_BITS_NARROW;
  assign tick     = (div_r == 16'h0000);
  assign sh_nxt   = {rxd_s2_r, sh_r[8:1]};
  assign rxd_edge = rxd_s2_r ^ rxd_d_r;
  assign wake_arm = wake_enable_i && !wake_used_r;
  // a single-shot that just finished must not start another char
  assign stop = overrun_error_flag_o || (!continuous_receive_enable &&
                (!single_receive_enable_o || m_done_r));

  // =========================================================
  // pin and slave done-toggle synchronisers
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rxd_s1_r   <= 1'b1;
      rxd_s2_r   <= 1'b1;
      rxd_d_r    <= 1'b1;
      s_tgl_s1_r <= 1'b0;
      s_tgl_s2_r <= 1'b0;
      s_tgl_d_r  <= 1'b0;
    end
    else
    begin
      rxd_s1_r   <= rx_data_pin_i;
      rxd_s2_r   <= rxd_s1_r;
      rxd_d_r    <= rxd_s2_r;
      s_tgl_s1_r <= s_tgl;
      s_tgl_s2_r <= s_tgl_s1_r;
      s_tgl_d_r  <= s_tgl_s2_r;
    end
  end

  assign s_done = (s_tgl_s2_r ^ s_tgl_d_r) && slv_act_r;

  // =========================================================
  // pin drivers and slave domain control
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_data_pin_o       <= 1'b0;
      rx_data_pin_oe_n_o  <= 1'b1;
      tx_clock_pin_oe_n_o <= 1'b1;
      slv_act_r           <= 1'b0;
      wide_cfg_r          <= 1'b0;
    end
    else
    begin
      rx_data_pin_o       <= 1'b0;
      rx_data_pin_oe_n_o  <= 1'b1;
      tx_clock_pin_oe_n_o <= !(serial_port_enable && sync_mode_i &&
                               clock_source_select_i);
      slv_act_r <= serial_port_enable && sync_mode_i && !clock_source_select_i &&
                   (single_receive_enable_o || continuous_receive_enable) &&
                   !overrun_error_flag_o;
      if (!slv_act_r)
      begin
        wide_cfg_r <= wide;
      end
    end
  end

  // link shifter stays in reset while slave reception is off
  assign link_nrst = nrst_i && slv_act_r;

  link_shifter u_link (
    .link_clk_i  (link_clk_i),
    .link_nrst_i (link_nrst),
    .wide_i      (wide_cfg_r),
    .rxd_i       (rx_data_pin_i),
    .word_o      (s_word),
    .done_tgl_o  (s_tgl)
  );

  // =========================================================
  // single-receive enable: set by software, cleared per char
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      single_receive_enable_o <= 1'b0;
    else if (!serial_port_enable)
      single_receive_enable_o <= 1'b0;
    else if (single_receive_set_i)
      single_receive_enable_o <= 1'b1;
    else if (m_done_r || s_done)
      single_receive_enable_o <= 1'b0;
  end

  // =========================================================
  // master clock generator and shifter, async receiver
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_r     <= ST_IDLE;
      div_r    <= `RX_DIV_RESET;
      bit_r    <= 4'h0;
      sh_r     <= `RX_CHAR_RESET;
      tx_clock_pin_o <= 1'b0;
      m_done_r <= 1'b0;
      m_word_r <= `RX_CHAR_RESET;
      m_framing_error_flag_r <= 1'b0;
    end
    else if (!serial_port_enable)
    begin
      st_r     <= ST_IDLE;
      div_r    <= `RX_DIV_RESET;
      bit_r    <= 4'h0;
      tx_clock_pin_o <= 1'b0;
      m_done_r <= 1'b0;
    end
    else
    begin
      m_done_r <= 1'b0;
      div_r    <= tick ? baud_divisor_i : div_r - 16'h0001;
      case (st_r)
        ST_IDLE:
        begin
          bit_r <= 4'h0;
          tx_clock_pin_o <= 1'b0;
          div_r <= baud_divisor_i;
          if (sync_mode_i && clock_source_select_i && !stop)
            st_r <= ST_CLK_LO;
          else if (!sync_mode_i && continuous_receive_enable && !overrun_error_flag_o &&
                   !wake_arm && rxd_d_r && !rxd_s2_r)
          begin
            st_r  <= ST_ASY_START;
            div_r <= {1'b0, baud_divisor_i[15:1]};
          end
        end
        ST_CLK_LO:
        begin
          if (stop)
            st_r <= ST_IDLE;
          else if (tick)
          begin
            tx_clock_pin_o <= 1'b1;
            st_r <= ST_CLK_HI;
          end
        end
        ST_CLK_HI:
        begin
          if (stop)
          begin
            tx_clock_pin_o <= 1'b0;
            st_r <= ST_IDLE;
          end
          else if (tick)
          begin
            tx_clock_pin_o <= 1'b0;
            sh_r <= sh_nxt;
            st_r <= ST_CLK_LO;
            if (bit_r == nbits - 4'h1)
            begin
              bit_r    <= 4'h0;
              m_done_r <= 1'b1;
              m_framing_error_flag_r <= 1'b0;
              m_word_r <= wide ? sh_nxt : {1'b0, sh_nxt[8:1]};
            end
            else
              bit_r <= bit_r + 4'h1;
          end
        end
        ST_ASY_START:
        begin
          if (!continuous_receive_enable)
            st_r <= ST_IDLE;
          else if (tick)
            st_r <= rxd_s2_r ? ST_IDLE : ST_ASY_BITS;
        end
        ST_ASY_BITS:
        begin
          if (!continuous_receive_enable)
            st_r <= ST_IDLE;
          else if (tick && bit_r == nbits)
          begin
            // stop bit low: framing error, e.g. a break char
            m_done_r <= 1'b1;
            m_framing_error_flag_r <= !rxd_s2_r;
            m_word_r <= wide ? sh_r : {1'b0, sh_r[8:1]};
            st_r     <= ST_IDLE;
          end
          else if (tick)
          begin
            sh_r  <= sh_nxt;
            bit_r <= bit_r + 4'h1;
          end
        end
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  // =========================================================
  // receive fifo
  assign push   = m_done_r || s_done;
  assign pent   = m_done_r ? {m_framing_error_flag_r, m_word_r} : {1'b0, s_word};
  assign pop    = data_read_i && (cnt_r != 2'h0);
  assign accept = push && !overrun_error_flag_o &&
                  (cnt_r != `RX_CNT_FULL || pop);
  assign ovr    = push && !overrun_error_flag_o &&
                  cnt_r == `RX_CNT_FULL && !pop;

  always_comb
  begin
    ent_nxt = ent_r;
    cnt_nxt = cnt_r;
    if (pop)
    begin
      ent_nxt[0] = ent_r[1];
      cnt_nxt    = cnt_r - 2'h1;
    end
    if (accept)
    begin
      ent_nxt[cnt_nxt[0]] = pent;
      cnt_nxt = cnt_nxt + 2'h1;
    end
  end

  generate
    for (genvar i = 0; i < `RX_FIFO_DEPTH; i++)
    begin : g_ent
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
          ent_r[i] <= `RX_ENT_RESET;
        else if (!serial_port_enable)
          ent_r[i] <= `RX_ENT_RESET;
        else
          ent_r[i] <= ent_nxt[i];
      end
    end
  endgenerate

  assign receive_data_o       = ent_r[0][7:0];
  assign ninth_received_bit_o = ent_r[0][8];
  assign framing_error_flag_o = ent_r[0][9];

  // =========================================================
  // overrun: set wins over a read or continuous clear in the same cycle; port disable clears it
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r                <= 2'h0;
      overrun_error_flag_o <= 1'b0;
      overrun_error_flag_cont_r          <= 1'b0;
    end
    else if (!serial_port_enable)
    begin
      cnt_r                <= 2'h0;
      overrun_error_flag_o <= 1'b0;
      overrun_error_flag_cont_r          <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      if (ovr)
      begin
        overrun_error_flag_o <= 1'b1;
        overrun_error_flag_cont_r          <= continuous_receive_enable;
      end
      else if (overrun_error_flag_cont_r ? !continuous_receive_enable : data_read_i)
        overrun_error_flag_o <= 1'b0;
    end
  end

  // =========================================================
  // wake on break, receive flag, interrupt, break detect
  always_comb
  begin
    wake_nxt = wake_r;
    if (data_read_i)
      wake_nxt = 1'b0;
    if (wake_arm && rxd_edge && wcnt_r == `RX_WAKE_EDGES - 2'h1)
      wake_nxt = 1'b1;
  end

  assign rflag_nxt = (cnt_nxt != 2'h0) || wake_nxt;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wake_r         <= 1'b0;
      wcnt_r         <= 2'h0;
      wake_used_r    <= 1'b0;
      receive_flag_o <= 1'b0;
      receive_int_o  <= 1'b0;
      break_detect_o <= 1'b0;
    end
    else if (!serial_port_enable)
    begin
      wake_r         <= 1'b0;
      wcnt_r         <= 2'h0;
      wake_used_r    <= 1'b0;
      receive_flag_o <= 1'b0;
      receive_int_o  <= 1'b0;
      break_detect_o <= 1'b0;
    end
    else
    begin
      wake_r <= wake_nxt;
      if (!wake_enable_i)
      begin
        wcnt_r      <= 2'h0;
        wake_used_r <= 1'b0;
      end
      else if (wake_arm && rxd_edge)
      begin
        wcnt_r      <= wcnt_r + 2'h1;
        wake_used_r <= (wcnt_r == `RX_WAKE_EDGES - 2'h1);
      end
      receive_flag_o <= rflag_nxt;
      receive_int_o  <= rflag_nxt && receive_int_enable_i;
      break_detect_o <= (cnt_nxt != 2'h0) && ent_nxt[0][9] &&
                        ent_nxt[0][7:0] == 8'h00;
    end
  end

  // =========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  break_needs_flags_a: assert property (
    break_detect_o |-> receive_flag_o && framing_error_flag_o &&
                       receive_data_o == 8'h00)
    else $error("break shown without its flags");
  data_pin_quiet_a: assert property (
    ##1 rx_data_pin_oe_n_o)
    else $error("data pin driven by receiver");
  single_clears_a: assert property (
    m_done_r && !continuous_receive_enable && serial_port_enable && !single_receive_set_i
    |=> !single_receive_enable_o ##1 st_r == ST_IDLE)
    else $error("single receive did not stop after one char");
  cont_abort_a: assert property (
    (st_r == ST_CLK_HI) && !continuous_receive_enable && !single_receive_enable_o && serial_port_enable
    |=> st_r == ST_IDLE && !tx_clock_pin_o)
    else $error("clock kept running after continuous cleared");
  flag_tracks_fifo_a: assert property (
    cnt_r != 2'h0 |-> receive_flag_o)
    else $error("receive flag low with unread data");
  overrun_set_a: assert property (
    ovr && serial_port_enable |=> overrun_error_flag_o && cnt_r == `RX_CNT_FULL)
    else $error("overrun not flagged or fifo lost");
  overrun_hold_a: assert property (
    overrun_error_flag_o && !pop && serial_port_enable |=> cnt_r == $past(cnt_r))
    else $error("char accepted during overrun");
  slave_clk_pin_a: assert property (
    serial_port_enable && sync_mode_i && !clock_source_select_i |=> tx_clock_pin_oe_n_o)
    else $error("clock pin driven in slave mode");
  pop_advance_a: assert property (
    pop && !push && serial_port_enable |=> cnt_r == $past(cnt_r) - 2'h1)
    else $error("read did not pop fifo");
  int_gate_a: assert property (
    receive_int_o == (receive_flag_o && $past(receive_int_enable_i)))
    else $error("interrupt not flag and enable");

  master_char_c: cover property (m_done_r && sync_mode_i);
  slave_char_c: cover property (s_done);
  overrun_c: cover property (ovr);
  break_c: cover property (break_detect_o);

endmodule : usart_sync_receiver

/* File: dv/sync_partner.sv */
// model of the far-side synchronous serial device
`timescale 1ns/1ps

module sync_partner (
  input  wire logic sck_i,
  input  wire logic nine_i,
  output logic      sdat_o,
  output logic      link_clk_o
);
  logic [8:0] words [3];
  int         bit_n = 0;
  int         chr_n = 0;

  initial
  begin
    sdat_o     = 1'b1;
    link_clk_o = 1'b0;
  end

  // ==========================================
  // master mode: answer the unit's clock
  always @(posedge sck_i)
  begin
    sdat_o = words[chr_n % 3][bit_n];
    bit_n  = bit_n + 1;
  end

  // hold time over: the line stops showing the last bit
  always @(negedge sck_i)
  begin
    if (bit_n >= (nine_i ? 9 : 8))
    begin
      bit_n  = 0;
      chr_n  = chr_n + 1;
      sdat_o = ~sdat_o;
    end
  end

  task automatic arm(input logic [8:0] w0, w1, w2);
    words[0] = w0;
    words[1] = w1;
    words[2] = w2;
    bit_n    = 0;
    chr_n    = 0;
  endtask : arm

  // ==========================================
  // slave mode: clock runs only within the frame
  task automatic clock_out(input logic [8:0] w, input int n);
    for (int i = 0; i < n; i++)
    begin
      #24;
      link_clk_o = 1'b1;
      sdat_o     = w[i];
      #24;
      link_clk_o = 1'b0;
    end
    #24;
    sdat_o = ~sdat_o;
  endtask : clock_out

  // asynchronous line level held for a while
  task automatic line(input logic lvl, input int ns);
    sdat_o = lvl;
    #(ns);
  endtask : line
endmodule : sync_partner

/* File: dv/usart_sync_receiver_tb.sv */
// self-checking bench for the serial receiver
`timescale 1ns/1ps

module usart_sync_receiver_tb;
  logic        clk = 1'b0, nrst = 1'b0, serial_port_enable = 1'b0, sync = 1'b1;
  logic        clock_source_select = 1'b1, sset = 1'b0, continuous_receive_enable = 1'b0, nine = 1'b0;
  logic        rie = 1'b0, wake = 1'b0, rd = 1'b0;
  logic [15:0] div = 16'h0003;
  logic        rxd, lclk, rxo, rx_oe_n, sck, sck_oe_n;
  logic        d9, framing_error_flag, overrun_error_flag, single_receive_enable, rflag, rint, brk;
  logic [7:0]  rdata;
  int          mismatches = 0, comparisons = 0, rises = 0;

  usart_sync_receiver u_dut (
    .clk_i(clk), .nrst_i(nrst), .link_clk_i(lclk),
    .serial_port_enable_i(serial_port_enable), .sync_mode_i(sync),
    .clock_source_select_i(clock_source_select), .single_receive_set_i(sset),
    .continuous_receive_enable_i(continuous_receive_enable), .nine_bit_receive_enable_i(nine),
    .receive_int_enable_i(rie), .wake_enable_i(wake),
    .baud_divisor_i(div), .data_read_i(rd), .rx_data_pin_i(rxd),
    .rx_data_pin_o(rxo), .rx_data_pin_oe_n_o(rx_oe_n),
    .tx_clock_pin_o(sck), .tx_clock_pin_oe_n_o(sck_oe_n),
    .receive_data_o(rdata), .ninth_received_bit_o(d9),
    .framing_error_flag_o(framing_error_flag), .overrun_error_flag_o(overrun_error_flag),
    .single_receive_enable_o(single_receive_enable), .receive_flag_o(rflag),
    .receive_int_o(rint), .break_detect_o(brk)
  );

  sync_partner u_far (
    .sck_i(sck), .nine_i(nine), .sdat_o(rxd), .link_clk_o(lclk)
  );

  initial forever #20 clk = ~clk;
  always @(posedge sck) rises = rises + 1;

  // ==========================================
  // hang guard, well beyond the expected run
  initial
  begin
    #2_000_000;
    mismatches = mismatches + 1;
    report_and_stop();
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // ==========================================
  // helpers: inputs move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic check(input logic [8:0] got, exp, input string what);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : check
  task automatic read_pop();
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(1);
  endtask : read_pop
  task automatic start_single();
    sset = 1'b1;
    cyc(1);
    sset = 1'b0;
  endtask : start_single
  task automatic wait_flag(input int lim);
    for (int k = 0; k < lim && rflag !== 1'b1; k++)
      cyc(1);
  endtask : wait_flag

  // ==========================================
  // scenarios
  task automatic t_single(input logic [8:0] w, input logic n9);
    nine = n9;
    u_far.arm(w, w, w);
    rises = 0;
    start_single();
    cyc(1);
    check(single_receive_enable, 1'b1, "single enable");
    check(rx_oe_n, 1'b1, "data pin driven");
    check(rxo, 1'b0, "data pin level");
    check(sck_oe_n, 1'b0, "master clock not driven");
    wait_flag(200);
    check(single_receive_enable, 1'b0, "single not cleared");
    check(d9, w[8] & n9, "ninth bit");
    check(rdata, w[7:0], "data");
    cyc(30);
    check(rises, n9 ? 9'h9 : 9'h8, "clock count");
    check(rflag, 1'b1, "flag held");
    check(rint, rie, "interrupt");
    read_pop();
    check(rflag, 1'b0, "flag after read");
  endtask : t_single

  task automatic t_single_overrun();
    nine = 1'b0;
    u_far.arm(9'h011, 9'h022, 9'h033);
    for (int i = 0; i < 3; i++)
    begin
      start_single();
      cyc(100);
    end
    check(overrun_error_flag, 1'b1, "overrun");
    check(rdata, 8'h11, "oldest kept");
    read_pop();
    check(overrun_error_flag, 1'b0, "read clears");
    check(rdata, 8'h22, "second entry");
    read_pop();
  endtask : t_single_overrun

  task automatic t_cont();
    int r;
    u_far.arm(9'h03c, 9'h0c3, 9'h05a);
    rises = 0;
    continuous_receive_enable = 1'b1;
    start_single();
    wait_flag(200);
    check(single_receive_enable, 1'b0, "single after first");
    cyc(60);
    check(rises > 14, 1'b1, "clocks paused");
    cyc(100);
    check(overrun_error_flag, 1'b1, "cont overrun");
    r = rises;
    cyc(40);
    check(rises, r, "clocks in overrun");
    check(rdata, 8'h3c, "cont oldest");
    read_pop();
    check(rdata, 8'hc3, "cont second");
    check(overrun_error_flag, 1'b1, "read cleared");
    continuous_receive_enable = 1'b0;
    cyc(2);
    check(overrun_error_flag, 1'b0, "continuous_receive_enable clear");
    read_pop();
  endtask : t_cont

  task automatic t_abort();
    u_far.arm(9'h0ff, 9'h0ff, 9'h0ff);
    rises = 0;
    continuous_receive_enable = 1'b1;
    for (int k = 0; k < 100 && rises < 3; k++)
      cyc(1);
    continuous_receive_enable = 1'b0;
    cyc(2);
    check(sck, 1'b0, "clock stopped");
    cyc(100);
    check(rises, 9'h3, "more clocks");
    check(rflag, 1'b0, "partial kept");
  endtask : t_abort

  task automatic t_slave();
    clock_source_select = 1'b0;
    continuous_receive_enable = 1'b1;
    cyc(3);
    check(sck_oe_n, 1'b1, "slave clock driven");
    u_far.clock_out(9'h0b6, 8);
    wait_flag(20);
    check(rdata, 8'hb6, "slave data");
    continuous_receive_enable = 1'b0;
    read_pop();
    clock_source_select = 1'b1;
  endtask : t_slave

  task automatic t_async();
    logic [9:0] f;
    sync = 1'b0;
    continuous_receive_enable = 1'b1;
    u_far.line(1'b1, 800);
    u_far.line(1'b0, 13 * 160);
    u_far.line(1'b1, 800);
    check(brk, 1'b1, "break");
    check(framing_error_flag, 1'b1, "framing");
    check(rdata, 8'h00, "break data");
    read_pop();
    wake = 1'b1;
    u_far.line(1'b0, 400);
    u_far.line(1'b1, 400);
    check(rflag, 1'b1, "wake flag");
    read_pop();
    f = {1'b1, 8'h6d, 1'b0};
    for (int i = 0; i < 10; i++)
      u_far.line(f[i], 160);
    u_far.line(1'b1, 800);
    check(rdata, 8'h6d, "after wake");
    check(framing_error_flag, 1'b0, "good stop flagged");
    check(brk, 1'b0, "false break");
    wake = 1'b0;
  endtask : t_async

  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    nrst = 1'b1;
    check(sck_oe_n, 1'b1, "reset clock drive");
    check(rflag, 1'b0, "reset flag");
    serial_port_enable = 1'b1;
    cyc(3);
    t_single(9'h0a5, 1'b0);
    rie = 1'b1;
    t_single(9'h15a, 1'b1);
    t_single_overrun();
    t_cont();
    t_abort();
    t_slave();
    t_async();
    report_and_stop();
  end
endmodule : usart_sync_receiver_tb
